// ==== hdl/usb_desc_pkg.sv ====
// Package of constants, field layouts and carrier types for the descriptor block.
package usb_desc_pkg;

  // Byte counts of the descriptors served by this block.
  localparam int unsigned CFG_BYTES = 9;
  localparam int unsigned IFC_BYTES = 9;
  localparam int unsigned EP_BYTES  = 7;

  // Byte offsets inside the configuration descriptor.
  localparam logic [3:0] CFG_OFS_TYPE  = 4'h1;
  localparam logic [3:0] CFG_OFS_ATTR  = 4'h7;
  localparam logic [3:0] CFG_OFS_POWER = 4'h8;

  // Byte offsets inside an endpoint descriptor.
  localparam logic [3:0] EP_OFS_LEN      = 4'h0;
  localparam logic [3:0] EP_OFS_TYPE     = 4'h1;
  localparam logic [3:0] EP_OFS_ADDR     = 4'h2;
  localparam logic [3:0] EP_OFS_ATTR     = 4'h3;
  localparam logic [3:0] EP_OFS_MPS_LO   = 4'h4;
  localparam logic [3:0] EP_OFS_MPS_HI   = 4'h5;
  localparam logic [3:0] EP_OFS_INTERVAL = 4'h6;

  // Fixed configuration descriptor type byte.
  localparam logic [7:0] CFG_TYPE_VAL = 8'h02;

  // Power byte defaults for self and bus powered operation.
  localparam logic [7:0] POWER_SELF = 8'h01;
  localparam logic [7:0] POWER_BUS  = 8'hfa;

  // Attribute byte layout: bit 7 always set, bit 6 self powered,
  // bit 5 remote wakeup; the bus powered, wakeup case gives a0h.
  localparam logic [7:0] ATTR_BASE     = 8'h80;
  localparam int unsigned ATTR_SELF_BIT = 6;
  localparam int unsigned ATTR_WAKE_BIT = 5;
  localparam logic [7:0] ATTR_DEFAULT  = 8'ha0;

  // Reset images of the configuration and interface descriptors.
  localparam logic [8:0][7:0] CFG_RST = {
    POWER_BUS, ATTR_DEFAULT, 8'h00, 8'h01, 8'h01,
    8'h00, 8'h27, CFG_TYPE_VAL, 8'h09};
  localparam logic [8:0][7:0] IFC_RST = {
    8'h00, 8'hff, 8'h00, 8'hff, 8'h03, 8'h00, 8'h00, 8'h04, 8'h09};

  // Endpoint descriptor constants.
  localparam logic [7:0]  EP_LEN_VAL   = 8'h07;
  localparam logic [7:0]  EP_TYPE_VAL  = 8'h05;
  localparam logic [7:0]  EP1_ADDR     = 8'h81;
  localparam logic [7:0]  EP2_ADDR     = 8'h02;
  localparam logic [7:0]  EP3_ADDR     = 8'h83;
  localparam logic [7:0]  ATTR_BULK    = 8'h02;
  localparam logic [7:0]  ATTR_INTR    = 8'h03;
  localparam logic [15:0] MPS_BULK_FS  = 16'h0040;
  localparam logic [15:0] MPS_BULK_HS  = 16'h0200;
  localparam logic [15:0] MPS_INTR     = 16'h0010;
  localparam logic [7:0]  BULK_IVL     = 8'h00;
  localparam logic [7:0]  INTR_IVL_HS  = 8'h04;
  localparam logic [7:0]  INTR_IVL_FS  = 8'h01;

  // Load port field selectors.
  localparam logic [4:0] LD_CFG_BASE = 5'h00;
  localparam logic [4:0] LD_IFC_BASE = 5'h09;
  localparam logic [4:0] LD_IVL_HS   = 5'h12;
  localparam logic [4:0] LD_IVL_FS   = 5'h13;

  // Which descriptor a request asks for.
  typedef enum logic [2:0] {
    KIND_CFG = 3'h0,
    KIND_IFC = 3'h1,
    KIND_EP1 = 3'h2,
    KIND_EP2 = 3'h3,
    KIND_EP3 = 3'h4
  } desc_kind_t;

  // Start-up states: two cycles fill the strap synchroniser, then capture.
  typedef enum logic [1:0] {
    ST_FILL0 = 2'h0,
    ST_FILL1 = 2'h1,
    ST_CAPT  = 2'h2,
    ST_LIVE  = 2'h3
  } phase_t;

  // A descriptor byte request.
  typedef struct packed {
    logic       valid;
    desc_kind_t kind;
    logic [3:0] idx;
  } desc_req_t;

  // A byte written by the non-volatile loader.
  typedef struct packed {
    logic       valid;
    logic [4:0] sel;
    logic [7:0] data;
  } ld_wr_t;

endpackage : usb_desc_pkg

// ==== hdl/usb_desc_defaults.sv ====
// Descriptor byte server for configuration, interface and endpoint data.
//
// Contract
// - Configuration type byte always reads 02h.
// - Power byte defaults 01h self, FAh bus.
// - Attribute default derives from sampled straps.
// - Compliance fields are loaded as written.
// - Interface zero loadable, defaults 09 04 00 00 03.
// - Class, subclass, protocol, string index freely loadable.
// - Endpoint one: fixed 81h, bulk 02h.
// - Endpoint two: fixed 02h, bulk.
// - Bulk packet size 64 full, 512 high.
// - Bulk interval byte reads 00h.
// - Endpoint length 07h, type 05h.
// - Interrupt endpoint loads only its interval.
// - Interrupt interval defaults 04h high, 01h full.
// - Attribute default a0h when the straps give bus powered, wakeup.
module usb_desc_defaults (
  // Clock and reset.
  input  wire logic                   core_clk_in,
  input  wire logic                   rst_n_in,
  // Strap pins, asynchronous to the core clock.
  input  wire logic                   power_source_strap_in,
  input  wire logic                   remote_wakeup_strap_in,
  // Current bus speed from the device controller, high when high speed.
  input  wire logic                   high_speed_in,
  // Loader write port.
  input  wire usb_desc_pkg::ld_wr_t   ld_wr_in,
  // Descriptor byte request.
  input  wire usb_desc_pkg::desc_req_t desc_req_in,
  // Descriptor byte answer.
  output logic [7:0]                  desc_data_out,
  output logic                        desc_valid_out,
  output logic                        desc_err_out,
  output logic                        ready_out
);

  // All state of the block in one record.
  typedef struct packed {
    usb_desc_pkg::phase_t phase;   // Start-up phase.
    logic [1:0]      sync1;        // First synchroniser stage of straps.
    logic [1:0]      sync2;        // Second synchroniser stage of straps.
    logic            self_pwr;     // Captured power source strap.
    logic            wake_en;      // Captured remote wakeup strap.
    logic [8:0][7:0] cfg;          // Configuration descriptor image.
    logic [8:0][7:0] ifc;          // Interface descriptor image.
    logic            attr_ld;      // Attribute byte came from the loader.
    logic            pwr_ld;       // Power byte came from the loader.
    logic [7:0]      ivl_hs;       // Interrupt interval at high speed.
    logic [7:0]      ivl_fs;       // Interrupt interval at full speed.
    logic [7:0]      data;         // Answer byte.
    logic            valid;        // Answer strobe.
    logic            err;          // Answer refused.
    logic            ready;        // Straps captured, requests served.
  } state_t;

  state_t q, d;

  // Builds one endpoint descriptor byte from the fixed tables.
  function automatic logic [7:0] ep_byte(
    input usb_desc_pkg::desc_kind_t k,
    input logic [3:0]               i,
    input logic                     hs,
    input logic [7:0]               ivl
  );
    logic [7:0]  adr;
    logic [7:0]  atr;
    logic [15:0] mps;
    logic [7:0]  itv;
    // Bulk endpoints are fixed constants; only the interval of the
    // interrupt endpoint is ever taken from loaded data.
    case (k)
      usb_desc_pkg::KIND_EP1: begin
        adr = usb_desc_pkg::EP1_ADDR;
        atr = usb_desc_pkg::ATTR_BULK;
        mps = hs ? usb_desc_pkg::MPS_BULK_HS
                 : usb_desc_pkg::MPS_BULK_FS;
        itv = usb_desc_pkg::BULK_IVL;
      end
      usb_desc_pkg::KIND_EP2: begin
        adr = usb_desc_pkg::EP2_ADDR;
        atr = usb_desc_pkg::ATTR_BULK;
        mps = hs ? usb_desc_pkg::MPS_BULK_HS
                 : usb_desc_pkg::MPS_BULK_FS;
        itv = usb_desc_pkg::BULK_IVL;
      end
      default: begin
        adr = usb_desc_pkg::EP3_ADDR;
        atr = usb_desc_pkg::ATTR_INTR;
        mps = usb_desc_pkg::MPS_INTR;
        itv = ivl;
      end
    endcase
    case (i)
      usb_desc_pkg::EP_OFS_LEN:  ep_byte = usb_desc_pkg::EP_LEN_VAL;
      usb_desc_pkg::EP_OFS_TYPE: ep_byte = usb_desc_pkg::EP_TYPE_VAL;
      usb_desc_pkg::EP_OFS_ADDR:     ep_byte = adr;
      usb_desc_pkg::EP_OFS_ATTR:     ep_byte = atr;
      usb_desc_pkg::EP_OFS_MPS_LO:   ep_byte = mps[7:0];
      usb_desc_pkg::EP_OFS_MPS_HI:   ep_byte = mps[15:8];
      usb_desc_pkg::EP_OFS_INTERVAL: ep_byte = itv;
      default:                       ep_byte = 8'h00;
    endcase
  endfunction

  // Default attribute byte from the captured straps.
  logic [7:0] strap_attr;
  // Default power byte from the captured power source strap.
  logic [7:0] strap_pwr;

  // Strap-derived defaults; each stands only until the loader writes its own byte.
  always_comb begin
    strap_attr = usb_desc_pkg::ATTR_BASE;
    strap_attr[usb_desc_pkg::ATTR_SELF_BIT] = q.self_pwr;
    strap_attr[usb_desc_pkg::ATTR_WAKE_BIT] = q.wake_en;
    strap_pwr = q.self_pwr ? usb_desc_pkg::POWER_SELF
                           : usb_desc_pkg::POWER_BUS;
  end

  // Next-state logic for the whole block.
  always_comb begin
    d       = q;
    d.valid = 1'b0;
    d.err   = 1'b0;
    // The first stage feeds only the second stage.
    d.sync1 = {power_source_strap_in, remote_wakeup_strap_in};
    d.sync2 = q.sync1;

    // Start-up: wait until the synchroniser holds the pin levels.
    case (q.phase)
      usb_desc_pkg::ST_FILL0: d.phase = usb_desc_pkg::ST_FILL1;
      usb_desc_pkg::ST_FILL1: d.phase = usb_desc_pkg::ST_CAPT;
      usb_desc_pkg::ST_CAPT: begin
        d.self_pwr = q.sync2[1];
        d.wake_en  = q.sync2[0];
        d.phase    = usb_desc_pkg::ST_LIVE;
      end
      default: d.phase = usb_desc_pkg::ST_LIVE;
    endcase
    // Ready is kept as its own flop so that the pin has no decode
    // behind it; it rises together with the live phase.
    d.ready = (d.phase == usb_desc_pkg::ST_LIVE);

    // Loader writes; values are stored untouched so that the loaded
    // compliance fields are served as programmed.
    if (ld_wr_in.valid) begin
      if (ld_wr_in.sel < usb_desc_pkg::LD_IFC_BASE) begin
        // A loaded type byte is dropped; the fixed value is served.
        if (ld_wr_in.sel[3:0] != usb_desc_pkg::CFG_OFS_TYPE) begin
          d.cfg[ld_wr_in.sel[3:0]] = ld_wr_in.data;
        end
        if (ld_wr_in.sel[3:0] == usb_desc_pkg::CFG_OFS_ATTR) begin
          d.attr_ld = 1'b1;
        end
        if (ld_wr_in.sel[3:0] == usb_desc_pkg::CFG_OFS_POWER) begin
          d.pwr_ld = 1'b1;
        end
      end else if (ld_wr_in.sel < usb_desc_pkg::LD_IVL_HS) begin
        d.ifc[4'(ld_wr_in.sel - usb_desc_pkg::LD_IFC_BASE)] =
          ld_wr_in.data;
      end else if (ld_wr_in.sel == usb_desc_pkg::LD_IVL_HS) begin
        d.ivl_hs = ld_wr_in.data;
      end else if (ld_wr_in.sel == usb_desc_pkg::LD_IVL_FS) begin
        d.ivl_fs = ld_wr_in.data;
      end
    end

    // Requests are answered one cycle later; before capture the straps
    // are not yet known, so requests are refused.
    if (desc_req_in.valid) begin
      d.valid = 1'b1;
      d.data  = 8'h00;
      if (q.phase != usb_desc_pkg::ST_LIVE) begin
        d.err = 1'b1;
      end else begin
        case (desc_req_in.kind)
          usb_desc_pkg::KIND_CFG: begin
            if (desc_req_in.idx >= 4'(usb_desc_pkg::CFG_BYTES)) begin
              d.err = 1'b1;
            end else if (desc_req_in.idx == usb_desc_pkg::CFG_OFS_TYPE) begin
              d.data = usb_desc_pkg::CFG_TYPE_VAL;
            end else if (desc_req_in.idx == usb_desc_pkg::CFG_OFS_ATTR &&
                         !q.attr_ld) begin
              d.data = strap_attr;
            end else if (desc_req_in.idx == usb_desc_pkg::CFG_OFS_POWER &&
                         !q.pwr_ld) begin
              d.data = strap_pwr;
            end else begin
              d.data = q.cfg[desc_req_in.idx];
            end
          end
          usb_desc_pkg::KIND_IFC: begin
            if (desc_req_in.idx >= 4'(usb_desc_pkg::IFC_BYTES)) begin
              d.err = 1'b1;
            end else begin
              d.data = q.ifc[desc_req_in.idx];
            end
          end
          usb_desc_pkg::KIND_EP1, usb_desc_pkg::KIND_EP2,
          usb_desc_pkg::KIND_EP3: begin
            if (desc_req_in.idx >= 4'(usb_desc_pkg::EP_BYTES)) begin
              d.err = 1'b1;
            end else begin
              // Speed is taken as it stands in the request cycle.
              d.data = ep_byte(desc_req_in.kind, desc_req_in.idx,
                               high_speed_in,
                               high_speed_in ? q.ivl_hs : q.ivl_fs);
            end
          end
          default: d.err = 1'b1;
        endcase
      end
    end

    // Synchronous reset loads the default images.
    if (!rst_n_in) begin
      d.phase    = usb_desc_pkg::ST_FILL0;
      d.sync1    = 2'h0;
      d.sync2    = 2'h0;
      d.self_pwr = 1'b0;
      d.wake_en  = 1'b1;
      d.cfg      = usb_desc_pkg::CFG_RST;
      d.ifc      = usb_desc_pkg::IFC_RST;
      d.attr_ld  = 1'b0;
      d.pwr_ld   = 1'b0;
      d.ivl_hs   = usb_desc_pkg::INTR_IVL_HS;
      d.ivl_fs   = usb_desc_pkg::INTR_IVL_FS;
      d.data     = 8'h00;
      d.valid    = 1'b0;
      d.err      = 1'b0;
      d.ready    = 1'b0;
    end
  end

  // The single state register.
  always_ff @(posedge core_clk_in) begin
    q <= d;
  end

  // Outputs come straight from the state register.
  assign desc_data_out  = q.data;
  assign desc_valid_out = q.valid;
  assign desc_err_out   = q.err;
  assign ready_out      = q.ready;

  // Checks, all on the core clock and quiet during reset.
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  // A live request of one kind and byte.
  sequence req_at(usb_desc_pkg::desc_kind_t k, logic [3:0] i);
    desc_req_in.valid && ready_out && desc_req_in.kind == k &&
      desc_req_in.idx == i;
  endsequence

  chk_cfg_type_fixed: assert property (
    req_at(usb_desc_pkg::KIND_CFG, 4'h1) |=> desc_valid_out &&
      !desc_err_out && desc_data_out == 8'h02)
    else $error("configuration type byte not 02h");

  chk_power_default: assert property (
    req_at(usb_desc_pkg::KIND_CFG, 4'h8) ##0 !q.pwr_ld |=>
      desc_data_out == ($past(q.self_pwr) ? 8'h01 : 8'hfa))
    else $error("power byte default wrong");

  chk_attr_from_straps: assert property (
    req_at(usb_desc_pkg::KIND_CFG, 4'h7) ##0 !q.attr_ld |=>
      desc_data_out == {1'b1, $past(q.self_pwr), $past(q.wake_en), 5'h00})
    else $error("attribute byte not from straps");

  // A loader write of a byte, one quiet cycle, then a request for the
  // same byte; the quiet cycle matches a loader that never writes on
  // consecutive edges.
  sequence load_then_read(logic [4:0] s, usb_desc_pkg::desc_kind_t k,
                          logic [3:0] i);
    ld_wr_in.valid && ld_wr_in.sel == s ##2 req_at(k, i);
  endsequence

  chk_iface_class_load: assert property (
    load_then_read(5'h0e, usb_desc_pkg::KIND_IFC, 4'h5) |=>
      desc_data_out == $past(ld_wr_in.data, 3))
    else $error("interface class not taken from loader");

  chk_cfg_type_load: assert property (
    load_then_read(5'h01, usb_desc_pkg::KIND_CFG, 4'h1) |=>
      desc_data_out == 8'h02)
    else $error("loaded configuration type not ignored");

  chk_ep1_address: assert property (
    req_at(usb_desc_pkg::KIND_EP1, 4'h2) ##1 1'b1 |->
      desc_data_out == 8'h81)
    else $error("endpoint one address wrong");

  chk_ep2_address: assert property (
    req_at(usb_desc_pkg::KIND_EP2, 4'h2) |=> desc_data_out == 8'h02)
    else $error("endpoint two address wrong");

  chk_bulk_mps_speed: assert property (
    req_at(usb_desc_pkg::KIND_EP2, 4'h5) |=>
      desc_data_out == ($past(high_speed_in) ? 8'h02 : 8'h00))
    else $error("bulk packet size high byte wrong");

  chk_bulk_interval: assert property (
    req_at(usb_desc_pkg::KIND_EP1, 4'h6) |=> desc_data_out == 8'h00)
    else $error("bulk interval not zero");

  chk_ep_len_type: assert property (
    (req_at(usb_desc_pkg::KIND_EP3, 4'h0) |=> desc_data_out == 8'h07) and
    (req_at(usb_desc_pkg::KIND_EP3, 4'h1) |=> desc_data_out == 8'h05))
    else $error("endpoint length or type wrong");

  chk_intr_interval: assert property (
    req_at(usb_desc_pkg::KIND_EP3, 4'h6) |=> desc_data_out ==
      ($past(high_speed_in) ? $past(q.ivl_hs) : $past(q.ivl_fs)))
    else $error("interrupt interval not per speed");

  chk_intr_defaults: assert property (
    $rose(rst_n_in) |-> q.ivl_hs == 8'h04 && q.ivl_fs == 8'h01)
    else $error("interrupt interval defaults wrong");

  chk_startup_refuse: assert property (
    $rose(rst_n_in) |-> !ready_out [*3] ##1 ready_out)
    else $error("start-up phase length wrong");

endmodule : usb_desc_defaults

// ==== testbench/desc_host_model.sv ====
// Host-side model that asks the block for descriptor bytes and keeps answers.
module desc_host_model (
  // Clock.
  input  wire logic                    core_clk_in,
  // Answer from the descriptor block.
  input  wire logic [7:0]              desc_data_in,
  input  wire logic                    desc_valid_in,
  input  wire logic                    desc_err_in,
  // Request and current bus speed towards the block.
  output usb_desc_pkg::desc_req_t      desc_req_out,
  output logic                         high_speed_out
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam time DRV = 1ns;  // Drive delay after each rising edge.

  logic [7:0] got_data [16];  // Answer bytes of the last burst.
  logic       got_err  [16];  // Refusal flags of the last burst.
  logic       got_vld  [16];  // Answer strobes of the last burst.

  // Start quiet so that no request is seen during reset.
  initial begin
    desc_req_out   = '0;
    high_speed_out = 1'b0;
  end

  // An idle port shows scrambled fields, so stale values can never pass.
  task automatic idle();
    desc_req_out = '{1'b0, usb_desc_pkg::desc_kind_t'(~desc_req_out.kind),
                     ~desc_req_out.idx};
  endtask

  // Sends n requests from offset i0; gap idle cycles between them models a
  // slow host, gap 0 sends one request every cycle.
  task automatic fetch(input logic [2:0] k, input logic [3:0] i0,
                       input int n, input int gap, input logic [15:0] hs);
    for (int i = 0; i < n; i++) begin
      high_speed_out = hs[i];
      desc_req_out   = '{1'b1, usb_desc_pkg::desc_kind_t'(k), i0 + 4'(i)};
      @(posedge core_clk_in);
      #DRV;
      got_data[i] = desc_data_in;
      got_err[i]  = desc_err_in;
      got_vld[i]  = desc_valid_in;
      if (gap > 0 || i == n - 1) begin
        idle();
        repeat (gap) begin
          @(posedge core_clk_in);
          #DRV;
        end
      end
    end
    @(posedge core_clk_in);
    #DRV;
  endtask
endmodule // desc_host_model

// ==== testbench/usb_desc_defaults_test.sv ====
// Self-checking bench for the descriptor byte server.
module usb_desc_defaults_test;
  timeunit 1ns;
  timeprecision 100ps;

  localparam time DRV = 1ns;  // Input change delay after each rising edge.

  logic                    core_clk_in;             // 125 MHz core clock.
  logic                    rst_n_in;                // Synchronous reset.
  logic                    power_source_strap_in;   // High means self powered.
  logic                    remote_wakeup_strap_in;  // High means wakeup on.
  logic                    high_speed_in;           // Driven by the host.
  usb_desc_pkg::ld_wr_t    ld_wr_in;                // Loader write port.
  usb_desc_pkg::desc_req_t desc_req_in;             // Driven by the host.
  logic [7:0]              desc_data_out;
  logic                    desc_valid_out;
  logic                    desc_err_out;
  logic                    ready_out;
  int                      n_fail;                  // Mismatches seen.
  int                      n_tests;                 // Comparisons made.

  usb_desc_defaults u_usb_desc_defaults (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .power_source_strap_in(power_source_strap_in),
    .remote_wakeup_strap_in(remote_wakeup_strap_in),
    .high_speed_in(high_speed_in), .ld_wr_in(ld_wr_in),
    .desc_req_in(desc_req_in), .desc_data_out(desc_data_out),
    .desc_valid_out(desc_valid_out), .desc_err_out(desc_err_out),
    .ready_out(ready_out));

  desc_host_model u_desc_host_model (
    .core_clk_in(core_clk_in), .desc_data_in(desc_data_out),
    .desc_valid_in(desc_valid_out), .desc_err_in(desc_err_out),
    .desc_req_out(desc_req_in), .high_speed_out(high_speed_in));

  // Free-running 8 ns clock.
  initial core_clk_in = 1'b0;
  always #4 core_clk_in = ~core_clk_in;

  // Guards against a hang anywhere in the sequence.
  initial begin
    repeat (20000) @(posedge core_clk_in);
    n_fail++;
    end_of_test();
  end

  // Byte comparison.
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // Flag comparison.
  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // Reset with the given straps; straps are only sampled after release.
  task automatic do_reset(input logic self_pwr, input logic wake);
    rst_n_in               = 1'b0;
    power_source_strap_in  = self_pwr;
    remote_wakeup_strap_in = wake;
    repeat (12) @(posedge core_clk_in);
    #DRV;
    rst_n_in = 1'b1;
  endtask

  // Bounded wait for the strap capture to finish.
  task automatic wait_ready();
    int cnt;
    cnt = 0;
    while (ready_out !== 1'b1 && cnt < 16) begin
      @(posedge core_clk_in);
      #DRV;
      cnt++;
    end
    chk_bit(ready_out, 1'b1);
    if (ready_out !== 1'b1) begin
      end_of_test();
    end
  endtask

  // One loader write; a spare cycle keeps back-to-back calls clean.
  task automatic load(input logic [4:0] sel, input logic [7:0] data);
    ld_wr_in = '{1'b1, sel, data};
    @(posedge core_clk_in);
    #DRV;
    ld_wr_in = '{1'b0, ~sel, ~data};
    @(posedge core_clk_in);
    #DRV;
  endtask

  // Reads a run of bytes and compares each with the expected list.
  task automatic expect_bytes(input logic [2:0] k, input logic [3:0] i0,
      input int gap, input logic [15:0] hs, input logic [7:0] exp[$]);
    u_desc_host_model.fetch(k, i0, exp.size(), gap, hs);
    foreach (exp[i]) begin
      chk_bit(u_desc_host_model.got_vld[i], 1'b1);
      chk_bit(u_desc_host_model.got_err[i], 1'b0);
      chk_byte(u_desc_host_model.got_data[i], exp[i]);
    end
  endtask

  // A refused request still answers, with the error flag and a zero byte.
  task automatic expect_refusal(input logic [2:0] k, input logic [3:0] i);
    u_desc_host_model.fetch(k, i, 1, 0, 16'h0000);
    chk_bit(u_desc_host_model.got_vld[0], 1'b1);
    chk_bit(u_desc_host_model.got_err[0], 1'b1);
    chk_byte(u_desc_host_model.got_data[0], 8'h00);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("Comparisons: %0d, mismatches: %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    n_fail   = 0;
    n_tests  = 0;
    ld_wr_in = '0;
    do_reset(1'b0, 1'b1);
    // Straps are not captured yet, so the first request is refused.
    chk_bit(ready_out, 1'b0);
    expect_refusal(3'h0, 4'h0);
    wait_ready();
    expect_bytes(3'h0, 4'h0, 0, 16'h0000, '{8'h09, 8'h02, 8'h27, 8'h00,
      8'h01, 8'h01, 8'h00, 8'ha0, 8'hfa});
    expect_bytes(3'h1, 4'h0, 0, 16'h0000, '{8'h09, 8'h04, 8'h00, 8'h00,
      8'h03, 8'hff, 8'h00, 8'hff, 8'h00});
    // Endpoints at full then high speed, fast host then slow host.
    for (int s = 0; s < 2; s++) begin
      expect_bytes(3'h2, 4'h0, s, {16{s[0]}}, '{8'h07, 8'h05, 8'h81, 8'h02,
        s ? 8'h00 : 8'h40, s ? 8'h02 : 8'h00, 8'h00});
      expect_bytes(3'h3, 4'h0, s, {16{s[0]}}, '{8'h07, 8'h05, 8'h02, 8'h02,
        s ? 8'h00 : 8'h40, s ? 8'h02 : 8'h00, 8'h00});
      expect_bytes(3'h4, 4'h0, s, {16{s[0]}}, '{8'h07, 8'h05, 8'h83, 8'h03,
        8'h10, 8'h00, s ? 8'h04 : 8'h01});
    end
    // Speed flips between back-to-back requests.
    expect_bytes(3'h2, 4'h3, 0, 16'h0004,
      '{8'h02, 8'h40, 8'h02, 8'h00});
    // Loader writes: the type byte write must be ignored.
    load(5'h01, 8'h55);
    load(5'h07, 8'h40);
    load(5'h08, 8'h32);
    load(5'h0e, 8'h12);
    load(5'h0f, 8'h34);
    load(5'h10, 8'h56);
    load(5'h11, 8'h78);
    load(5'h12, 8'h0a);
    load(5'h13, 8'h07);
    load(5'h14, 8'h99);
    expect_bytes(3'h0, 4'h0, 0, 16'h0000, '{8'h09, 8'h02, 8'h27, 8'h00,
      8'h01, 8'h01, 8'h00, 8'h40, 8'h32});
    expect_bytes(3'h1, 4'h5, 0, 16'h0000,
      '{8'h12, 8'h34, 8'h56, 8'h78});
    expect_bytes(3'h4, 4'h0, 0, 16'h0040, '{8'h07, 8'h05, 8'h83, 8'h03,
      8'h10, 8'h00, 8'h0a});
    expect_bytes(3'h4, 4'h6, 0, 16'h0000, '{8'h07});
    expect_bytes(3'h2, 4'h0, 0, 16'h0000, '{8'h07, 8'h05, 8'h81});
    // A load, one spare cycle, then a read of the very same byte.
    load(5'h0e, 8'h5a);
    expect_bytes(3'h1, 4'h5, 0, 16'h0000, '{8'h5a});
    load(5'h01, 8'h66);
    expect_bytes(3'h0, 4'h1, 0, 16'h0000, '{8'h02});
    // Offsets past the end and unknown kinds are refused.
    expect_refusal(3'h0, 4'h9);
    expect_refusal(3'h1, 4'h9);
    expect_refusal(3'h3, 4'h7);
    for (int k = 5; k < 8; k++) begin
      expect_refusal(3'(k), 4'h0);
    end
    // Second reset: self powered without wakeup, loaded values gone.
    do_reset(1'b1, 1'b0);
    wait_ready();
    expect_bytes(3'h0, 4'h7, 0, 16'h0000, '{8'hc0, 8'h01});
    expect_bytes(3'h4, 4'h6, 0, 16'h0001, '{8'h04});
    end_of_test();
  end
endmodule // usb_desc_defaults_test
